// ===== rtl/tec_event_cfg.sv
// Event and power configuration register with event pin control
// Overview of operation
// - D0 selects comparator or interrupt event mode
// - Locks freeze mode, polarity, critical-only, enable
// - D1 selects event pin active level
// - D2 restricts events to critical trips
// - D3 zero keeps event pin deasserted
// - D4 reads back current pin assertion
// - Writing D4 changes nothing
// - D5 one clears latched interrupt event
// - Clear has no effect in comparator mode
// - Clear bit not stored, reads zero
// - Critical condition holds event, ignores clear
// - Alarm lock refuses window trip writes
// - Critical lock refuses critical trip writes
// - Locks stick until power-on reset
// - One write sets a lock
// - Shutdown stops sensing and events
// - Locks block setting shutdown, not clearing
// - D10:D9 selects trip hysteresis
// - Temperature compared against three trip limits
`timescale 1ns/100ps
module tec_event_cfg #(
   parameter int TW = 13                 // Temperature word width
) (
   input  wire logic          ref_clk,     // 200 MHz system clock
   input  wire logic          rst_n,       // Power-on reset, active low
   input  wire logic          reg_wr,      // Register write strobe
   input  wire logic [3:0]    reg_ptr,     // Register pointer
   input  wire logic [15:0]   reg_wdata,   // Write data
   output logic      [15:0]   reg_rdata,   // Read data, one cycle late
   input  wire logic          temp_sample, // New conversion strobe
   input  wire logic [TW-1:0] temp_value,  // Conversion result
   output logic               sensing_core_en, // Sensing core run
   output logic               event_o,     // Event pin drive level
   output logic               event_oe     // Event pin pull-down enable
);
   // Identity words, values arbitrary
   localparam logic [15:0] MFG_ID = 16'h5A5A;
   localparam logic [15:0] DEV_ID = 16'h0100;

   // Width check: comparator is built for 13-bit words
   if (TW != 13) begin : g_tw_chk
      $error("tec_event_cfg: TW must be 13");
   end

   tec_cmp_if #(.TW(TW)) cif ();         // Link to comparator

   logic [15:0]   cfg_q, cfg_d;          // Stored configuration
   logic [15:0]   up_q, up_d;            // Alarm upper trip
   logic [15:0]   lo_q, lo_d;            // Alarm lower trip
   logic [15:0]   cr_q, cr_d;            // Critical trip
   logic [TW-1:0] temp_q, temp_d;        // Latched temperature
   logic          evt_q, evt_d;          // Internal event state
   logic          cond_q, cond_d;        // Last trip condition
   logic          stat_q, stat_d;        // Pin asserted status
   logic          oe_q, oe_d;            // Registered pull-down
   logic [15:0]   rd_q, rd_d;            // Read data register
   logic          cfg_wr;                // Write to configuration
   logic          locked;                // Either lock set
   logic          clr_evt;               // Clear-event request
   logic          cond_w;                // Current trip condition
   tec_pkg::tec_mode_e mode;             // Event mode view

   assign cfg_wr  = reg_wr && (reg_ptr == tec_pkg::PTR_CFG);
   assign locked  = cfg_q[tec_pkg::B_LOCKA] || cfg_q[tec_pkg::B_LOCKC];
   // clear strobe from write of one
   assign clr_evt = cfg_wr && reg_wdata[tec_pkg::B_CLR];
   assign mode    = tec_pkg::tec_mode_e'(cfg_q[tec_pkg::B_MODE]);

   // Configuration next value
   always_comb begin
      cfg_d = cfg_q;
      if (cfg_wr) begin
         if (!locked) begin
            cfg_d[3:0] = reg_wdata[3:0];
         end
         cfg_d[tec_pkg::B_LOCKA] = cfg_q[tec_pkg::B_LOCKA]
                                   | reg_wdata[tec_pkg::B_LOCKA];
         cfg_d[tec_pkg::B_LOCKC] = cfg_q[tec_pkg::B_LOCKC]
                                   | reg_wdata[tec_pkg::B_LOCKC];
         if (!reg_wdata[tec_pkg::B_SHUT] || !locked) begin
            cfg_d[tec_pkg::B_SHUT] = reg_wdata[tec_pkg::B_SHUT];
         end
         cfg_d[10:9] = reg_wdata[10:9];
      end
      cfg_d[tec_pkg::B_STAT] = 1'b0;
      cfg_d[tec_pkg::B_CLR]  = 1'b0;
      cfg_d[15:11]           = 5'h00;
   end

   // Trip limit next values; the lock check sits on the write path
   always_comb begin
      up_d = up_q;
      lo_d = lo_q;
      cr_d = cr_q;
      if (reg_wr && !cfg_q[tec_pkg::B_LOCKA]) begin
         if (reg_ptr == tec_pkg::PTR_UPPER) begin
            up_d = reg_wdata & tec_pkg::TRIP_MASK;
         end
         if (reg_ptr == tec_pkg::PTR_LOWER) begin
            lo_d = reg_wdata & tec_pkg::TRIP_MASK;
         end
      end
      if (reg_wr && !cfg_q[tec_pkg::B_LOCKC]
          && reg_ptr == tec_pkg::PTR_CRIT) begin
         cr_d = reg_wdata & tec_pkg::TRIP_MASK;
      end
   end

   // Register file storage
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg_q <= tec_pkg::CFG_RST;
         up_q  <= tec_pkg::TRIP_RST;
         lo_q  <= tec_pkg::TRIP_RST;
         cr_q  <= tec_pkg::TRIP_RST;
      end else begin
         cfg_q <= cfg_d;
         up_q  <= up_d;
         lo_q  <= lo_d;
         cr_q  <= cr_d;
      end
   end

   // Comparator hookup
   assign cif.temp  = temp_q;
   assign cif.upper = up_q;
   assign cif.lower = lo_q;
   assign cif.crit  = cr_q;
   assign cif.hyst  = cfg_q[10:9];
   assign cif.halt  = cfg_q[tec_pkg::B_SHUT];

   tec_trip_cmp u_cmp (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .cif     (cif.cmp)
   );

   assign sensing_core_en = !cfg_q[tec_pkg::B_SHUT];

   // Event state next values
   always_comb begin
      temp_d = temp_q;
      // Conversions ignored while the core is off
      if (temp_sample && !cfg_q[tec_pkg::B_SHUT]) begin
         temp_d = temp_value;
      end
      cond_w = cif.crit_trip
               || (!cfg_q[tec_pkg::B_CRITO] && (cif.above || cif.below));
      cond_d = cond_w;
      if (mode == tec_pkg::TEC_COMPARE) begin
         evt_d = cond_w;
      end else begin
         // new trip beats clear, critical holds
         evt_d = (cond_w && !cond_q) || cif.crit_trip
                 || (evt_q && !clr_evt);
      end
      if (cfg_q[tec_pkg::B_SHUT]) begin
         evt_d = 1'b0;
      end
      stat_d = evt_d && cfg_d[tec_pkg::B_OUTEN];
      // pull down when pin level is low
      oe_d   = cfg_d[tec_pkg::B_POL] ? !stat_d : stat_d;
   end

   // Event state storage
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         temp_q <= '0;
         evt_q  <= 1'b0;
         cond_q <= 1'b0;
         stat_q <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         temp_q <= temp_d;
         evt_q  <= evt_d;
         cond_q <= cond_d;
         stat_q <= stat_d;
         oe_q   <= oe_d;
      end
   end

   // Open drain: the pin only ever pulls low
   assign event_o  = 1'b0;
   assign event_oe = oe_q;

   // Read mux, unmapped pointers read zero
   always_comb begin
      unique case (reg_ptr)
         tec_pkg::PTR_CAP:   rd_d = tec_pkg::CAP_VAL;
         tec_pkg::PTR_CFG: begin
            rd_d = cfg_q;
            rd_d[tec_pkg::B_STAT] = stat_q;
         end
         tec_pkg::PTR_UPPER: rd_d = up_q;
         tec_pkg::PTR_LOWER: rd_d = lo_q;
         tec_pkg::PTR_CRIT:  rd_d = cr_q;
         tec_pkg::PTR_TEMP:
            rd_d = {cif.crit_trip, cif.above, cif.below, temp_q[12:0]};
         tec_pkg::PTR_MFG:   rd_d = MFG_ID;
         tec_pkg::PTR_DEV:   rd_d = DEV_ID;
         default:            rd_d = 16'h0000;
      endcase
   end

   // Read data register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_q <= 16'h0000;
      end else begin
         rd_q <= rd_d;
      end
   end
   assign reg_rdata = rd_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_cmp_follow;
      (mode == tec_pkg::TEC_COMPARE && !cfg_q[tec_pkg::B_SHUT])
         |=> evt_q == $past(cond_w);
   endproperty
   a_cmp_follow: assert property (p_cmp_follow)
      else $error("comparator mode event does not follow trip");

   property p_lock_low;
      (cfg_wr && locked) |=> cfg_q[3:0] == $past(cfg_q[3:0]);
   endproperty
   a_lock_low: assert property (p_lock_low)
      else $error("locked mode bits changed");

   property p_pol_pin;
      ##1 event_oe == ($past(cfg_d[tec_pkg::B_POL]) ^ stat_q);
   endproperty
   a_pol_pin: assert property (p_pol_pin)
      else $error("event pin level wrong for polarity");

   // Watch the event state itself, not the mask expression
   property p_crit_only;
      (mode == tec_pkg::TEC_COMPARE && cfg_q[tec_pkg::B_CRITO]
       && !cif.crit_trip) |=> !evt_q;
   endproperty
   a_crit_only: assert property (p_crit_only)
      else $error("alarm event passed in critical-only mode");

   property p_out_dis;
      !cfg_d[tec_pkg::B_OUTEN] |=> !stat_q;
   endproperty
   a_out_dis: assert property (p_out_dis)
      else $error("event asserted while output disabled");

   property p_cfg_read;
      (reg_ptr == tec_pkg::PTR_CFG) |=>
         reg_rdata[tec_pkg::B_CLR] == 1'b0
         && reg_rdata[tec_pkg::B_STAT] == $past(stat_q);
   endproperty
   a_cfg_read: assert property (p_cfg_read)
      else $error("config read shows wrong status or clear bit");

   sequence s_int_clear;
      mode == tec_pkg::TEC_INTR && clr_evt && !cif.crit_trip
      && !(cond_w && !cond_q);
   endsequence
   property p_int_clear;
      s_int_clear |=> !evt_q;
   endproperty
   a_int_clear: assert property (p_int_clear)
      else $error("interrupt event not cleared");

   property p_crit_hold;
      (mode == tec_pkg::TEC_INTR && cif.crit_trip
       && !cfg_q[tec_pkg::B_SHUT]) |=> evt_q;
   endproperty
   a_crit_hold: assert property (p_crit_hold)
      else $error("event dropped during critical trip");

   property p_lock_alarm;
      (reg_wr && cfg_q[tec_pkg::B_LOCKA]) |=> $stable(up_q) && $stable(lo_q);
   endproperty
   a_lock_alarm: assert property (p_lock_alarm)
      else $error("alarm trip written while locked");

   property p_lock_crit;
      (reg_wr && cfg_q[tec_pkg::B_LOCKC]) |=> $stable(cr_q);
   endproperty
   a_lock_crit: assert property (p_lock_crit)
      else $error("critical trip written while locked");

   property p_lock_stick;
      locked |=> locked[*3];
   endproperty
   a_lock_stick: assert property (p_lock_stick)
      else $error("lock bit cleared without reset");

   property p_lock_once;
      (cfg_wr && reg_wdata[tec_pkg::B_LOCKA]) |=> cfg_q[tec_pkg::B_LOCKA];
   endproperty
   a_lock_once: assert property (p_lock_once)
      else $error("single write did not set lock");

   sequence s_shut2;
      cfg_q[tec_pkg::B_SHUT] ##1 cfg_q[tec_pkg::B_SHUT];
   endsequence
   property p_shut_quiet;
      s_shut2 |-> !evt_q && !sensing_core_en;
   endproperty
   a_shut_quiet: assert property (p_shut_quiet)
      else $error("event while shut down");

   property p_shut_lock;
      (cfg_wr && locked && !cfg_q[tec_pkg::B_SHUT])
         |=> !cfg_q[tec_pkg::B_SHUT];
   endproperty
   a_shut_lock: assert property (p_shut_lock)
      else $error("shutdown set while locked");
endmodule

// ===== pkg/tec_pkg.sv
// Constants shared by the thermal event configuration block
package tec_pkg;
   // Register pointer values
   localparam logic [3:0]  PTR_CAP   = 4'h0;
   localparam logic [3:0]  PTR_CFG   = 4'h1;
   localparam logic [3:0]  PTR_UPPER = 4'h2;
   localparam logic [3:0]  PTR_LOWER = 4'h3;
   localparam logic [3:0]  PTR_CRIT  = 4'h4;
   localparam logic [3:0]  PTR_TEMP  = 4'h5;
   localparam logic [3:0]  PTR_MFG   = 4'h6;
   localparam logic [3:0]  PTR_DEV   = 4'h7;
   // Configuration field positions
   localparam int          B_MODE    = 0;
   localparam int          B_POL     = 1;
   localparam int          B_CRITO   = 2;
   localparam int          B_OUTEN   = 3;
   localparam int          B_STAT    = 4;
   localparam int          B_CLR     = 5;
   localparam int          B_LOCKA   = 6;
   localparam int          B_LOCKC   = 7;
   localparam int          B_SHUT    = 8;
   localparam int          B_HYST    = 9;
   // Reset and fixed values
   localparam logic [15:0] CFG_RST   = 16'h0000;
   localparam logic [15:0] TRIP_RST  = 16'h0000;
   localparam logic [15:0] CAP_VAL   = 16'h001D;
   localparam logic [15:0] TRIP_MASK = 16'h1FFC;
   // Hysteresis in sixteenths of a degree
   localparam logic [6:0]  HYS_0     = 7'h00;
   localparam logic [6:0]  HYS_1P5   = 7'h18;
   localparam logic [6:0]  HYS_3     = 7'h30;
   localparam logic [6:0]  HYS_6     = 7'h60;
   // Event output modes
   typedef enum logic {TEC_COMPARE = 1'b0, TEC_INTR = 1'b1} tec_mode_e;
endpackage

// ===== pkg/tec_cmp_if.sv
// Interface between the configuration block and its trip comparator
`timescale 1ns/100ps
interface tec_cmp_if #(parameter int TW = 13);
   logic [TW-1:0] temp;      // Latched temperature, twos complement
   logic [15:0]   upper;     // Alarm window upper trip register
   logic [15:0]   lower;     // Alarm window lower trip register
   logic [15:0]   crit;      // Critical trip register
   logic [1:0]    hyst;      // Hysteresis select
   logic          halt;      // Sensing shut down
   logic          above;     // Above alarm window
   logic          below;     // Below alarm window
   logic          crit_trip; // At or above critical
   modport ctl (output temp, upper, lower, crit, hyst, halt,
                input above, below, crit_trip);
   modport cmp (input temp, upper, lower, crit, hyst, halt,
                output above, below, crit_trip);
endinterface

// ===== rtl/tec_trip_cmp.sv
// Trip comparator with selectable hysteresis
`timescale 1ns/100ps
module tec_trip_cmp (
   input  wire logic ref_clk, // System clock
   input  wire logic rst_n,   // Synchronous reset, active low
   tec_cmp_if.cmp    cif      // Temperature, limits and trip flags
);
   logic signed [14:0] t_w;     // Widened temperature
   logic signed [14:0] up_w;    // Widened limits in 1/16 degree
   logic signed [14:0] lo_w;
   logic signed [14:0] cr_w;
   logic signed [14:0] hy_w;    // Hysteresis amount
   logic               above_d, below_d, crit_d;
   logic               above_q, below_q, crit_q;

   // Hysteresis pulls each release point back into the safe side
   always_comb begin
      t_w  = $signed({{2{cif.temp[12]}}, cif.temp[12:0]});
      up_w = $signed({{2{cif.upper[12]}}, cif.upper[12:2], 2'b00});
      lo_w = $signed({{2{cif.lower[12]}}, cif.lower[12:2], 2'b00});
      cr_w = $signed({{2{cif.crit[12]}}, cif.crit[12:2], 2'b00});
      unique case (cif.hyst)
         2'b00: hy_w = $signed({8'h00, tec_pkg::HYS_0});
         2'b01: hy_w = $signed({8'h00, tec_pkg::HYS_1P5});
         2'b10: hy_w = $signed({8'h00, tec_pkg::HYS_3});
         2'b11: hy_w = $signed({8'h00, tec_pkg::HYS_6});
      endcase
      above_d = above_q ? (t_w > up_w - hy_w) : (t_w > up_w);
      below_d = below_q ? (t_w < lo_w + hy_w) : (t_w < lo_w);
      crit_d  = crit_q  ? (t_w >= cr_w - hy_w) : (t_w >= cr_w);
      if (cif.halt) begin
         above_d = 1'b0;
         below_d = 1'b0;
         crit_d  = 1'b0;
      end
   end

   // Flag registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         above_q <= 1'b0;
         below_q <= 1'b0;
         crit_q  <= 1'b0;
      end else begin
         above_q <= above_d;
         below_q <= below_d;
         crit_q  <= crit_d;
      end
   end

   assign cif.above     = above_q;
   assign cif.below     = below_q;
   assign cif.crit_trip = crit_q;

   // Held critical flag survives small drops inside the band
   property p_crit_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      (crit_q && !cif.halt && t_w >= cr_w - hy_w) |=> crit_q;
   endproperty
   a_crit_hold: assert property (p_crit_hold)
      else $error("critical flag released inside hysteresis band");

   property p_halt_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      cif.halt |=> !above_q && !below_q && !crit_q;
   endproperty
   a_halt_clear: assert property (p_halt_clear)
      else $error("trip flag set while shut down");
endmodule

// ===== dv/tec_host_model.sv
// Bus host model that reaches the event block registers
`timescale 1ns/100ps
module tec_host_model (
   input  wire logic        ref_clk,   // System clock
   output logic             reg_wr,    // Write strobe
   output logic [3:0]       reg_ptr,   // Register pointer
   output logic [15:0]      reg_wdata, // Write data
   input  wire logic [15:0] reg_rdata  // Read data
);
   // Idle bus before the first transfer
   initial begin
      reg_wr    = 1'b0;
      reg_ptr   = 4'h0;
      reg_wdata = 16'h0000;
   end

   task automatic wr(input logic [3:0] p, input logic [15:0] d);
      @(posedge ref_clk);
      #1;
      reg_wr    = 1'b1;
      reg_ptr   = p;
      reg_wdata = d;
      @(posedge ref_clk);
      #1;
      reg_wr    = 1'b0;
      // Released data is scrambled so no stale value helps
      reg_wdata = ~d;
   endtask

   // Pointer sampled on one edge, data ready after it
   task automatic rd(input logic [3:0] p, output logic [15:0] d);
      @(posedge ref_clk);
      #1;
      reg_ptr = p;
      @(posedge ref_clk);
      #1;
      d = reg_rdata;
   endtask
endmodule

// ===== dv/tec_event_cfg_test.sv
// Self-checking bench of the event configuration block
`timescale 1ns/100ps
module tec_event_cfg_test;
   localparam logic [3:0] CFG = tec_pkg::PTR_CFG; // Config pointer
   logic        ref_clk;         // System clock
   logic        rst_n;           // Reset, active low
   logic        reg_wr;          // Write strobe
   logic [3:0]  reg_ptr;         // Pointer
   logic [15:0] reg_wdata;       // Write data
   logic [15:0] reg_rdata;       // Read data
   logic        temp_sample;     // Conversion strobe
   logic [12:0] temp_value;      // Conversion result
   logic        sensing_core_en; // Core run
   logic        event_o;         // Pin data
   logic        event_oe;        // Pin pull-down
   int          n_errors;        // Mismatches
   int          cmp_count;       // Comparisons
   // Hysteresis per code, sixteenths of a degree
   logic [12:0] hys [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};

   // Clock at 200 MHz
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   tec_event_cfg #(.TW(13)) u_dut (
      .ref_clk         (ref_clk),
      .rst_n           (rst_n),
      .reg_wr          (reg_wr),
      .reg_ptr         (reg_ptr),
      .reg_wdata       (reg_wdata),
      .reg_rdata       (reg_rdata),
      .temp_sample     (temp_sample),
      .temp_value      (temp_value),
      .sensing_core_en (sensing_core_en),
      .event_o         (event_o),
      .event_oe        (event_oe)
   );

   tec_host_model u_host (
      .ref_clk   (ref_clk),
      .reg_wr    (reg_wr),
      .reg_ptr   (reg_ptr),
      .reg_wdata (reg_wdata),
      .reg_rdata (reg_rdata)
   );

   // Closing report, the single exit
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Compare and count
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Read a register and compare
   task automatic rdc(input logic [3:0] p, input logic [15:0] e);
      logic [15:0] v;
      u_host.rd(p, v);
      chk("reg_rdata", e, v);
   endtask

   // Pin enable check
   task automatic oe(input logic e);
      chk("event_oe", {15'h0000, e}, {15'h0000, event_oe});
   endtask

   // Core enable check
   task automatic en(input logic e);
      chk("sensing_core_en", {15'h0000, e}, {15'h0000, sensing_core_en});
   endtask

   // Let a write reach the pin, two edges
   task automatic w2;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   // One conversion, then wait until the pin shows it
   task automatic samp(input logic [12:0] t);
      @(posedge ref_clk);
      #1;
      temp_sample = 1'b1;
      temp_value  = t;
      @(posedge ref_clk);
      #1;
      temp_sample = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   // Watchdog, cuts a hang short
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("BAD watchdog expected finish seen timeout");
      give_verdict;
   end

   // Main sequence
   initial begin
      rst_n       = 1'b0;
      temp_sample = 1'b0;
      temp_value  = 13'h0000;
      n_errors    = 0;
      cmp_count   = 0;
      repeat (20) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      // Reset values and unmapped space
      rdc(CFG, tec_pkg::CFG_RST);
      en(1'b1);
      oe(1'b0);
      chk("event_o", 16'h0000, {15'h0000, event_o});
      rdc(tec_pkg::PTR_CAP, tec_pkg::CAP_VAL);
      rdc(4'hA, 16'h0000);
      // Window 5 to 50 degrees, critical at 100
      u_host.wr(tec_pkg::PTR_UPPER, 16'hE323);
      u_host.wr(tec_pkg::PTR_LOWER, 16'h0050);
      u_host.wr(tec_pkg::PTR_CRIT, 16'h0640);
      rdc(tec_pkg::PTR_UPPER, 16'h0320);
      // Comparator mode follows the condition
      u_host.wr(CFG, 16'h0008);
      samp(13'h03E8); oe(1'b1);
      rdc(tec_pkg::PTR_TEMP, 16'h43E8);
      rdc(CFG, 16'h0018);
      u_host.wr(CFG, 16'h0028); w2; oe(1'b1);
      rdc(CFG, 16'h0018);
      samp(13'h0190); oe(1'b0);
      u_host.wr(CFG, 16'h0018); w2; oe(1'b0);
      rdc(CFG, 16'h0008);
      samp(13'h0010); oe(1'b1);
      samp(13'h0190); oe(1'b0);
      // Active high pin, cool then hot
      u_host.wr(CFG, 16'h000A); w2; oe(1'b1);
      samp(13'h03E8); oe(1'b0);
      rdc(CFG, 16'h001A);
      chk("event_o", 16'h0000, {15'h0000, event_o});
      u_host.wr(CFG, 16'h0000); w2; oe(1'b0);
      rdc(CFG, 16'h0000);
      // Critical only asserts on a critical trip
      u_host.wr(CFG, 16'h000C); w2; oe(1'b0);
      samp(13'h06A4); oe(1'b1);
      rdc(tec_pkg::PTR_TEMP, 16'hC6A4);
      samp(13'h0190); oe(1'b0);
      // Interrupt mode latches, clear rules
      u_host.wr(CFG, 16'h0009); w2; oe(1'b0);
      samp(13'h06A4); oe(1'b1);
      u_host.wr(CFG, 16'h0029); w2; oe(1'b1);
      samp(13'h0190); oe(1'b1);
      u_host.wr(CFG, 16'h0029); w2; oe(1'b0);
      samp(13'h03E8); oe(1'b1);
      samp(13'h0190); oe(1'b1);
      u_host.wr(CFG, 16'h0009); w2; oe(1'b1);
      u_host.wr(CFG, 16'h0029); w2; oe(1'b0);
      // Every hysteresis code at its release boundary
      for (int h = 0; h < 4; h++) begin
         u_host.wr(CFG, {5'h00, h[1:0], 9'h008});
         samp(13'h0321); oe(1'b1);
         samp(13'h0321 - hys[h]); oe(1'b1);
         samp(13'h0320 - hys[h]); oe(1'b0);
         rdc(CFG, {5'h00, h[1:0], 9'h008});
      end
      // Shutdown stops sensing and events
      u_host.wr(CFG, 16'h0108); w2; en(1'b0);
      samp(13'h03E8); oe(1'b0);
      u_host.wr(CFG, 16'h0008); w2; en(1'b1);
      samp(13'h03E8); oe(1'b1);
      samp(13'h0190); oe(1'b0);
      // Locks, single write, shutdown still clearable
      u_host.wr(CFG, 16'h0108);
      u_host.wr(CFG, 16'h0148);
      rdc(CFG, 16'h0148);
      u_host.wr(CFG, 16'h0048); w2; en(1'b1);
      u_host.wr(tec_pkg::PTR_UPPER, 16'h0400);
      rdc(tec_pkg::PTR_UPPER, 16'h0320);
      u_host.wr(tec_pkg::PTR_LOWER, 16'h0000);
      rdc(tec_pkg::PTR_LOWER, 16'h0050);
      u_host.wr(tec_pkg::PTR_CRIT, 16'h0700);
      rdc(tec_pkg::PTR_CRIT, 16'h0700);
      u_host.wr(CFG, 16'h00C8);
      u_host.wr(tec_pkg::PTR_CRIT, 16'h0640);
      rdc(tec_pkg::PTR_CRIT, 16'h0700);
      u_host.wr(CFG, 16'h0107); w2; en(1'b1);
      rdc(CFG, 16'h00C8);
      // Only power-on reset frees the locks
      rst_n = 1'b0;
      w2;
      rst_n = 1'b1;
      rdc(CFG, tec_pkg::CFG_RST);
      rdc(tec_pkg::PTR_CRIT, tec_pkg::TRIP_RST);
      give_verdict;
   end
endmodule
